//--- src/scl_pkg.sv
// constants and types for the reset-time strap configuration loader
package scl_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int NSTRAP = 18;

	// position of each strap in the latched vector
	localparam int I_SW5_DUP = 0;
	localparam int I_SW5_SPD = 1;
	localparam int I_LED_MODE = 2;
	localparam int I_CFG_LO = 3;
	localparam int I_CFG_MID = 4;
	localparam int I_PHY5_EN = 5;
	localparam int I_AGING = 6;
	localparam int I_P4_AN = 7;
	localparam int I_SEL_LO = 8;
	localparam int I_SEL_HI = 9;
	localparam int I_XOVER = 10;
	localparam int I_FC = 11;
	localparam int I_BP = 12;
	localparam int I_EXCOL = 13;
	localparam int I_BACKOFF = 14;
	localparam int I_FRAME = 15;
	localparam int I_P4_DUP = 16;
	localparam int I_P4_FC = 17;

	// levels that the internal pulls give with no board resistor
	localparam logic [NSTRAP-1:0] STRAP_DEFAULT = 18'h000e0;
	// straps whose pins turn into outputs after the capture, port-5 ones only while their side is on
	localparam logic [NSTRAP-1:0] STRAP_DUAL = 18'h3f8e7;
	// dual pins that belong to the port-5 phy receive side
	localparam logic [NSTRAP-1:0] STRAP_PHY5_PINS = 18'h3f800;
	// dual pins that belong to the switch port-5 receive side
	localparam logic [NSTRAP-1:0] STRAP_SW5_PINS = 18'h00007;

	localparam int STRAP_SETTLE_NS = 40;
	localparam int STRAP_SETTLE_CYC =
		(STRAP_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	localparam int SCL_FREQ_HZ = 61_000;
	localparam int SCL_HALF_CYC = CLK_HZ / (2 * SCL_FREQ_HZ);

	localparam logic [10:0] FRAME_STD_BYTES = 11'h5f2;
	localparam logic [10:0] FRAME_BIG_BYTES = 11'h600;

	localparam int P4_AN_BIT = 7;
	localparam logic [2:0] LED_OFF = 3'h7;

	typedef enum logic [1:0] {
		SW5_OFF,
		SW5_PHY_MII,
		SW5_MAC_MII,
		SW5_PHY_SNI
	} scl_sw5_mode_t;

	typedef enum logic [1:0] {
		BUS_I2C,
		BUS_SMI,
		BUS_SPI,
		BUS_BIST
	} scl_bus_mode_t;
endpackage

//--- src/scl_strap_if.sv
// carrier for the latched strap vector between latch and decoder
interface scl_strap_if;
	import scl_pkg::*;
	logic [NSTRAP-1:0] bits;
	logic valid;
	modport src (output bits, output valid);
	modport dst (input bits, input valid);
endinterface

//--- src/scl_strap_latch.sv
// captures the strap levels once after reset release and holds them
module scl_strap_latch
	import scl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [NSTRAP-1:0] strap_in,
	scl_strap_if.src sif
);
	typedef enum logic {ST_WAIT, ST_HOLD} scl_latch_st_t;

	scl_latch_st_t st_q;
	logic [7:0] cnt_q;
	logic [NSTRAP-1:0] bits_q;
	wire logic take = (st_q == ST_WAIT) &&
		(cnt_q == 8'(STRAP_SETTLE_CYC - 1));

	// pull-ups settle for a short time after release before the capture
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q <= ST_WAIT;
			cnt_q <= 8'h00;
			bits_q <= STRAP_DEFAULT;
		end else begin
			case (st_q)
				ST_WAIT: begin
					cnt_q <= cnt_q + 8'h01;
					if (take) begin
						bits_q <= strap_in;
						st_q <= ST_HOLD;
					end
				end
				ST_HOLD: st_q <= ST_HOLD;
				default: st_q <= ST_WAIT;
			endcase
		end
	end

	assign sif.bits = bits_q;
	assign sif.valid = (st_q == ST_HOLD);

	chk_capture_value: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(sif.valid) |-> sif.bits == $past(strap_in))
		else $error("latched straps differ from pins at capture");

	chk_hold_stable: assert property (
		@(posedge clk_sys) disable iff (rst)
		sif.valid |=> sif.valid && $stable(sif.bits))
		else $error("latched straps changed before next reset");
endmodule

//--- src/scl_led_enc.sv
// per-port led bit encoder for the two strap-selected led modes
module scl_led_enc
	import scl_pkg::*;
#(
	parameter int NPORT = 5
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic mode1,
	input wire logic [NPORT-1:0] link_up,
	input wire logic [NPORT-1:0] link_speed100,
	input wire logic [NPORT-1:0] link_full,
	output logic [3*NPORT-1:0] port_led_bits
);
	genvar i;
	generate
		for (i = 0; i < NPORT; i++) begin : g_port
			wire logic is10 = ~link_speed100[i];
			wire logic half = ~link_full[i];
			wire logic [2:0] m0 = {1'b0, half, is10};
			wire logic [2:0] m1 = {is10, ~is10, half};
			// leds are active low, so no link shows all ones
			wire logic [2:0] enc = !link_up[i] ? LED_OFF :
				(mode1 ? m1 : m0);
			logic [2:0] led_q;

			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					led_q <= LED_OFF;
				end else begin
					led_q <= enc;
				end
			end
			assign port_led_bits[3*i +: 3] = led_q;

			chk_led_mode0: assert property (
				@(posedge clk_sys) disable iff (rst)
				link_up[i] && !mode1 |=>
				led_q == {1'b0, ~$past(link_full[i]),
				~$past(link_speed100[i])})
				else $error("mode 0 led pattern wrong");

			chk_led_mode1: assert property (
				@(posedge clk_sys) disable iff (rst)
				link_up[i] && mode1 && !link_speed100[i] |=>
				led_q[2:1] == 2'b10 && led_q[0] == ~$past(link_full[i]))
				else $error("mode 1 led pattern wrong at 10M");
		end
	endgenerate
endmodule

//--- src/scl_strap_cfg.sv
// strap capture, configuration decode and dual-use pin release
module scl_strap_cfg
	import scl_pkg::*;
#(
	parameter int NPORT = 5
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sw_port5_duplex_strap,
	input wire logic sw_port5_speed_strap,
	input wire logic led_mode_strap,
	input wire logic port5_cfg_mid_strap,
	input wire logic port5_cfg_low_strap,
	input wire logic phy5_if_enable_strap,
	input wire logic aging_strap,
	input wire logic port4_autoneg_strap,
	input wire logic serial_bus_sel_hi,
	input wire logic serial_bus_sel_lo,
	input wire logic crossover_disable_strap,
	input wire logic flow_ctrl_strap,
	input wire logic back_pressure_strap,
	input wire logic excess_collision_strap,
	input wire logic backoff_strap,
	input wire logic frame_size_strap,
	input wire logic port4_duplex_strap,
	input wire logic port4_force_fc_strap,
	input wire logic [NSTRAP-1:0] pin_func_out,
	output logic [NSTRAP-1:0] strap_pin_out,
	output logic [NSTRAP-1:0] strap_pin_oe_n,
	input wire logic [NPORT-1:0] link_up,
	input wire logic [NPORT-1:0] link_speed100,
	input wire logic [NPORT-1:0] link_full,
	output logic [3*NPORT-1:0] port_led_bits,
	input wire logic spi_select_n,
	input wire logic spi_tx_bit,
	output logic spi_serial_out,
	output logic spi_out_oe_n,
	input wire logic eeprom_present,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic port4_an_fail,
	input wire logic port4_an_full,
	output logic cfg_valid,
	output logic sw5_half_duplex,
	output logic sw5_speed_10,
	output logic led_mode1,
	output scl_sw5_mode_t sw5_mode,
	output logic sw5_tristate,
	output logic phy5_mii_en,
	output logic aging_en,
	output logic [7:0] port4_ctrl_init,
	output scl_bus_mode_t serial_bus_mode,
	output logic cfg_use_defaults,
	output logic auto_mdix_en,
	output logic flow_ctrl_en,
	output logic back_pressure_en,
	output logic excess_col_retry,
	output logic aggressive_backoff,
	output logic [10:0] max_frame_bytes,
	output logic port4_duplex_full,
	output logic port4_force_fc
);
	scl_strap_if sif ();

	wire logic [NSTRAP-1:0] strap_vec = {
		port4_force_fc_strap,
		port4_duplex_strap,
		frame_size_strap,
		backoff_strap,
		excess_collision_strap,
		back_pressure_strap,
		flow_ctrl_strap,
		crossover_disable_strap,
		serial_bus_sel_hi,
		serial_bus_sel_lo,
		port4_autoneg_strap,
		aging_strap,
		phy5_if_enable_strap,
		port5_cfg_mid_strap,
		port5_cfg_low_strap,
		led_mode_strap,
		sw_port5_speed_strap,
		sw_port5_duplex_strap
	};

	scl_strap_latch u_latch (
		.clk_sys (clk_sys),
		.rst (rst),
		.strap_in (strap_vec),
		.sif (sif.src)
	);

	wire logic [NSTRAP-1:0] s = sif.bits;
	assign cfg_valid = sif.valid;

	// port-5 role decode from the three configuration straps
	wire logic [2:0] cfg_code = {s[I_PHY5_EN], s[I_CFG_MID], s[I_CFG_LO]};
	assign sw5_mode = scl_sw5_mode_t'(cfg_code[1:0]);
	assign sw5_tristate = (sw5_mode == SW5_OFF);
	// code 100 keeps the phy side off even with its enable strap high
	assign phy5_mii_en = cfg_code[2] && (cfg_code[1:0] != 2'b00);

	assign sw5_half_duplex = s[I_SW5_DUP];
	assign sw5_speed_10 = s[I_SW5_SPD];
	assign led_mode1 = s[I_LED_MODE];
	assign aging_en = s[I_AGING];
	assign port4_ctrl_init = 8'(s[I_P4_AN]) << P4_AN_BIT;
	assign serial_bus_mode =
		scl_bus_mode_t'({s[I_SEL_HI], s[I_SEL_LO]});
	assign auto_mdix_en = ~s[I_XOVER];
	assign flow_ctrl_en = ~s[I_FC];
	assign back_pressure_en = s[I_BP];
	assign excess_col_retry = s[I_EXCOL];
	assign aggressive_backoff = s[I_BACKOFF];
	assign max_frame_bytes =
		s[I_FRAME] ? FRAME_BIG_BYTES : FRAME_STD_BYTES;
	assign port4_force_fc = s[I_P4_FC];

	// the forced duplex only matters when negotiation is off or failed
	wire logic p4_forced = ~s[I_P4_AN] | port4_an_fail;
	assign port4_duplex_full =
		p4_forced ? s[I_P4_DUP] : port4_an_full;

	wire logic i2c_mode = cfg_valid && (serial_bus_mode == BUS_I2C);
	assign cfg_use_defaults = i2c_mode && !eeprom_present;

	// dual-use pins: inputs while the straps settle, outputs afterwards unless they belong to a disabled port-5 side
	genvar i;
	generate
		for (i = 0; i < NSTRAP; i++) begin : g_pin
			wire logic side_on =
				(!STRAP_PHY5_PINS[i] || phy5_mii_en) &&
				(!STRAP_SW5_PINS[i] || !sw5_tristate);
			wire logic drive = cfg_valid && STRAP_DUAL[i] && side_on;
			logic out_q;

			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					out_q <= 1'b0;
				end else begin
					out_q <= pin_func_out[i];
				end
			end
			assign strap_pin_out[i] = drive ? out_q : 1'b0;
			assign strap_pin_oe_n[i] = ~drive;
		end
	endgenerate

	scl_led_enc #(
		.NPORT (NPORT)
	) u_led (
		.clk_sys (clk_sys),
		.rst (rst),
		.mode1 (led_mode1),
		.link_up (link_up),
		.link_speed100 (link_speed100),
		.link_full (link_full),
		.port_led_bits (port_led_bits)
	);

	// serial data out floats whenever the slave is not selected
	logic spi_q;
	wire logic spi_drive = cfg_valid && !spi_select_n &&
		(serial_bus_mode == BUS_SPI);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			spi_q <= 1'b0;
		end else begin
			spi_q <= spi_tx_bit;
		end
	end
	assign spi_serial_out = spi_drive ? spi_q : 1'b0;
	assign spi_out_oe_n = ~spi_drive;

	// eeprom clock: open drain, pulled low on the low half only
	logic [9:0] scl_cnt_q;
	logic scl_lvl_q;
	wire logic scl_run = i2c_mode && eeprom_present;
	wire logic scl_wrap = (scl_cnt_q == 10'(SCL_HALF_CYC - 1));

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scl_cnt_q <= 10'h000;
			scl_lvl_q <= 1'b1;
		end else if (!scl_run) begin
			scl_cnt_q <= 10'h000;
			scl_lvl_q <= 1'b1;
		end else if (scl_wrap) begin
			scl_cnt_q <= 10'h000;
			scl_lvl_q <= ~scl_lvl_q;
		end else begin
			scl_cnt_q <= scl_cnt_q + 10'h001;
		end
	end
	assign scl_out = 1'b0;
	assign scl_oe_n = ~(scl_run && !scl_lvl_q);

	chk_pins_reset_input: assert property (
		@(posedge clk_sys) disable iff (rst)
		!cfg_valid |-> strap_pin_oe_n == {NSTRAP{1'b1}})
		else $error("dual pin driven before straps latched");

	chk_sw5_duplex_cap: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(cfg_valid) |->
		sw5_half_duplex == $past(sw_port5_duplex_strap))
		else $error("switch port-5 duplex not from strap");

	chk_sw5_speed_cap: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(cfg_valid) |-> sw5_speed_10 == $past(sw_port5_speed_strap))
		else $error("switch port-5 speed not from strap");

	chk_port5_role: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(cfg_valid) |->
		sw5_mode == scl_sw5_mode_t'({$past(port5_cfg_mid_strap),
		$past(port5_cfg_low_strap)}))
		else $error("switch port-5 role decode wrong");

	chk_phy5_enable: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(cfg_valid) |-> phy5_mii_en == ($past(phy5_if_enable_strap)
		&& ($past(port5_cfg_mid_strap) || $past(port5_cfg_low_strap))))
		else $error("port-5 phy enable decode wrong");

	chk_phy5_tristate: assert property (
		@(posedge clk_sys) disable iff (rst)
		!phy5_mii_en |-> (~strap_pin_oe_n & STRAP_PHY5_PINS) == '0)
		else $error("phy-5 pin driven while phy side disabled");

	chk_p4_an_bit: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(cfg_valid) |-> port4_ctrl_init[7] == $past(port4_autoneg_strap)
		&& port4_ctrl_init[6:0] == 7'h00)
		else $error("port-4 autoneg bit not from strap");

	chk_spi_hiz: assert property (
		@(posedge clk_sys) disable iff (rst)
		spi_select_n || serial_bus_mode != BUS_SPI |-> spi_out_oe_n)
		else $error("serial out driven while deselected");

	chk_scl_toggle: assert property (
		@(posedge clk_sys) disable iff (rst)
		scl_run && scl_wrap |=> scl_lvl_q != $past(scl_lvl_q))
		else $error("eeprom clock missed its half-period edge");

	chk_scl_half_len: assert property (
		@(posedge clk_sys) disable iff (rst)
		scl_run && !scl_wrap ##1 scl_run |-> $stable(scl_lvl_q))
		else $error("eeprom clock changed before half period");

	chk_bus_defaults: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(cfg_valid) && !eeprom_present |-> cfg_use_defaults ==
		!($past(serial_bus_sel_hi) || $past(serial_bus_sel_lo)))
		else $error("default start flag wrong at capture");

	chk_frame_limit: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(cfg_valid) |-> max_frame_bytes ==
		($past(frame_size_strap) ? FRAME_BIG_BYTES : FRAME_STD_BYTES))
		else $error("frame size limit not from strap");

	chk_p4_forced_dup: assert property (
		@(posedge clk_sys) disable iff (rst)
		cfg_valid && (port4_an_fail || !port4_ctrl_init[7]) |->
		port4_duplex_full == s[I_P4_DUP])
		else $error("port-4 forced duplex ignores strap");

	chk_cfg_hold: assert property (
		@(posedge clk_sys) disable iff (rst)
		cfg_valid |=> cfg_valid && $stable(flow_ctrl_en) &&
		$stable(auto_mdix_en) && $stable(aging_en))
		else $error("configuration changed after capture");
endmodule

//--- dv/scl_strap_board.sv
// board strap resistors meeting the dual-use pins of the loader
module scl_strap_board
	import scl_pkg::*;
(
	input wire logic [NSTRAP-1:0] fitted_level,
	input wire logic [NSTRAP-1:0] strap_pin_out,
	input wire logic [NSTRAP-1:0] strap_pin_oe_n,
	output logic [NSTRAP-1:0] pin_level
);
	timeunit 1ns;
	timeprecision 100ps;
	// a released pin falls back to its resistor, a driven one shows the device
	assign pin_level = (strap_pin_out & ~strap_pin_oe_n) |
		(fitted_level & strap_pin_oe_n);
endmodule

//--- dv/strap_config_and_led_mode_tb.sv
// self-checking bench for the strap configuration loader
module strap_config_and_led_mode_tb
	import scl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, rst, sel_n, tx, ee, an_fail, an_full;
	logic [NSTRAP-1:0] board, so, soe;
	wire logic [NSTRAP-1:0] pins;
	logic [4:0] lu, ls, lf;
	logic [14:0] led;
	logic spo, spoe, sclo, scloe, valid, hd, s10, lm1, tri5, p5en, age;
	logic mdix, fc, bp, exc, agb, p4d, p4fc, usedef;
	scl_sw5_mode_t sw5m;
	scl_bus_mode_t busm;
	logic [7:0] p4ctl;
	logic [10:0] mfb;
	wire logic [35:0] dec_got = {hd, s10, lm1, sw5m, tri5, p5en, age, p4ctl,
		busm, mdix, fc, bp, exc, agb, mfb, p4d, p4fc};
	int errors = 0;
	int tests_run = 0;
	localparam logic [NSTRAP-1:0] FUNC = 18'h2aaaa;
	logic [NSTRAP-1:0] func;

	scl_strap_board board_u (.fitted_level(board), .strap_pin_out(so),
		.strap_pin_oe_n(soe), .pin_level(pins));
	scl_strap_cfg #(.NPORT(5)) dut_u (.clk_sys(clk_sys), .rst(rst),
		.sw_port5_duplex_strap(pins[0]), .sw_port5_speed_strap(pins[1]),
		.led_mode_strap(pins[2]), .port5_cfg_low_strap(pins[3]),
		.port5_cfg_mid_strap(pins[4]), .phy5_if_enable_strap(pins[5]),
		.aging_strap(pins[6]), .port4_autoneg_strap(pins[7]),
		.serial_bus_sel_lo(pins[8]), .serial_bus_sel_hi(pins[9]),
		.crossover_disable_strap(pins[10]), .flow_ctrl_strap(pins[11]),
		.back_pressure_strap(pins[12]), .excess_collision_strap(pins[13]),
		.backoff_strap(pins[14]), .frame_size_strap(pins[15]),
		.port4_duplex_strap(pins[16]), .port4_force_fc_strap(pins[17]),
		.pin_func_out(func), .strap_pin_out(so), .strap_pin_oe_n(soe),
		.link_up(lu), .link_speed100(ls), .link_full(lf),
		.port_led_bits(led), .spi_select_n(sel_n), .spi_tx_bit(tx),
		.spi_serial_out(spo), .spi_out_oe_n(spoe), .eeprom_present(ee),
		.scl_out(sclo), .scl_oe_n(scloe), .port4_an_fail(an_fail),
		.port4_an_full(an_full), .cfg_valid(valid), .sw5_half_duplex(hd),
		.sw5_speed_10(s10), .led_mode1(lm1), .sw5_mode(sw5m),
		.sw5_tristate(tri5), .phy5_mii_en(p5en), .aging_en(age),
		.port4_ctrl_init(p4ctl), .serial_bus_mode(busm),
		.cfg_use_defaults(usedef), .auto_mdix_en(mdix), .flow_ctrl_en(fc),
		.back_pressure_en(bp), .excess_col_retry(exc),
		.aggressive_backoff(agb), .max_frame_bytes(mfb),
		.port4_duplex_full(p4d), .port4_force_fc(p4fc));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	function automatic logic [35:0] exp_dec(logic [17:0] v);
		logic [1:0] c;
		logic p4f;
		c = v[4:3];
		// forced duplex only counts without a successful autoneg
		p4f = (!v[7] || an_fail) ? v[16] : an_full;
		return {v[0], v[1], v[2], c, c == 2'h0, v[5] & (c != 2'h0), v[6],
			v[7], 7'h00, v[9:8], ~v[10], ~v[11], v[12], v[13], v[14],
			v[15] ? FRAME_BIG_BYTES : FRAME_STD_BYTES, p4f, v[17]};
	endfunction

	function automatic logic [17:0] exp_oe(logic [17:0] v);
		logic [17:0] m;
		m = STRAP_DUAL;
		if (v[4:3] == 2'h0) begin
			m = m & ~STRAP_SW5_PINS;
		end
		if (!(v[5] && v[4:3] != 2'h0)) begin
			m = m & ~STRAP_PHY5_PINS;
		end
		return ~m;
	endfunction

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [35:0] e,
		input logic [35:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic apply_cfg(input logic [17:0] v);
		@(posedge clk_sys);
		rst <= 1'b1;
		board <= v;
		tick();
		chk("reset decode", exp_dec(STRAP_DEFAULT), dec_got);
		chk("reset pins", 36'({1'b0, 18'h3ffff}), 36'({valid, soe}));
		@(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("early valid", 36'h0, 36'(valid));
		tick();
		chk("valid", 36'h1, 36'(valid));
		chk("decode", exp_dec(v), dec_got);
		chk("pin oe", 36'(exp_oe(v)), 36'(soe));
		tick();
		chk("pin out", 36'(func & ~exp_oe(v)), 36'(so));
		@(posedge clk_sys);
		board <= ~v;
		// flip every pin function so each driven pin shows both levels
		func <= ~func;
		repeat (3) tick();
		chk("held decode", exp_dec(v), dec_got);
		chk("pin out new", 36'(func & ~exp_oe(v)), 36'(so));
	endtask

	task automatic t_straps();
		for (int i = 0; i < NSTRAP; i++) begin
			apply_cfg(STRAP_DEFAULT ^ (18'h1 << i));
		end
		apply_cfg(STRAP_DEFAULT | (18'h3 << I_SEL_LO));
		for (int c = 0; c < 8; c++) begin
			apply_cfg((STRAP_DEFAULT & ~18'h38) | 18'(c << I_CFG_LO));
		end
		$display("test straps done");
	endtask

	task automatic t_p4dup();
		@(posedge clk_sys);
		an_fail <= 1'b0;
		apply_cfg(STRAP_DEFAULT ^ 18'h10080);
		apply_cfg(STRAP_DEFAULT);
		for (int f = 0; f < 2; f++) begin
			@(posedge clk_sys);
			an_full <= f[0];
			tick();
			chk("an duplex", 36'(f[0]), 36'(p4d));
		end
		@(posedge clk_sys);
		an_fail <= 1'b1;
		an_full <= 1'b0;
		$display("test port4 duplex done");
	endtask

	task automatic t_leds();
		logic [11:0] tab;
		for (int m = 0; m < 2; m++) begin
			apply_cfg(STRAP_DEFAULT | 18'(m << I_LED_MODE));
			// pattern per k: bit1 = 10 Mbps, bit0 = half duplex
			tab = m ? 12'hb1a : 12'h650;
			for (int k = 0; k < 4; k++) begin
				@(posedge clk_sys);
				lu <= 5'h0f;
				ls <= {5{~k[1]}};
				lf <= {5{~k[0]}};
				repeat (2) tick();
				chk("leds", 36'({LED_OFF, {4{tab[3*k +: 3]}}}),
					36'(led));
			end
		end
		$display("test leds done");
	endtask

	task automatic t_spi();
		apply_cfg(STRAP_DEFAULT | (18'h1 << I_SEL_HI));
		tick();
		chk("spi idle oe", 36'h1, 36'(spoe));
		for (int b = 1; b >= 0; b--) begin
			@(posedge clk_sys);
			sel_n <= 1'b0;
			tx <= b[0];
			tick();
			chk("spi oe", 36'({1'b0, b[0]}), 36'({spoe, spo}));
		end
		@(posedge clk_sys);
		sel_n <= 1'b1;
		tick();
		chk("spi end oe", 36'h1, 36'(spoe));
		$display("test spi done");
	endtask

	task automatic phase(input logic lvl, output int n);
		n = 0;
		while (scloe === lvl && n < 2000) begin
			tick();
			n++;
		end
		if (n >= 2000) begin
			errors++;
			$display("BAD scl wait expected change seen none");
			final_report();
		end
	endtask

	task automatic t_scl();
		int n;
		@(posedge clk_sys);
		ee <= 1'b1;
		apply_cfg(STRAP_DEFAULT);
		@(posedge clk_sys);
		sel_n <= 1'b0;
		phase(1'b1, n);
		chk("spi oe in i2c", 36'h1, 36'(spoe));
		phase(1'b0, n);
		chk("scl low", 36'(SCL_HALF_CYC), 36'(n));
		phase(1'b1, n);
		chk("scl high", 36'(SCL_HALF_CYC), 36'({sclo, 11'(n)}));
		@(posedge clk_sys);
		ee <= 1'b0;
		sel_n <= 1'b1;
		apply_cfg(STRAP_DEFAULT);
		chk("use defaults", 36'h1, 36'(usedef));
		n = 0;
		repeat (1700) begin
			tick();
			n += (scloe === 1'b1) ? 0 : 1;
		end
		chk("scl stopped", 36'h0, 36'(n));
		$display("test scl done");
	endtask

	initial begin
		rst = 1'b1;
		board = STRAP_DEFAULT;
		func = FUNC;
		{sel_n, tx, ee, an_fail, an_full} = 5'b10010;
		{lu, ls, lf} = 15'h0;
		repeat (8) @(posedge clk_sys);
		t_straps();
		t_p4dup();
		t_leds();
		t_spi();
		t_scl();
		final_report();
	end
endmodule
